// [core/mtc_ch4_timer.sv]
// Channel 4 compare/capture timer with APB register access
//
// Overview of operation
// - Codes 1-3: initial low, then low/high/toggle.
// - Codes 5-7 start high; 0 and 4 retain.
// - Top bit set: capture rise, fall or both.
// - Pin low after reset until control written.
// - Buffer mode blocks C capture and compare.
// - Enable bit gates protected channel registers.
// - Buffer register always writable by CPU.
// - Blocked reads undefined, blocked writes dropped.
// - Clear on last match state: N+1 clocks.
// - Counter clear beats simultaneous counter write.
//
// Chosen here: the APB interface to the registers and the register offsets.
`include "mtc_timer_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module mtc_ch4_timer
   import mtc_pkg::*;
(
   // APB clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB request
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   // APB answer
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Channel 4 C pin
   input wire logic c_pin_in,
   output logic c_pin_out,
   output logic c_pin_oe
);
   mtc_apb_req_t req;

   logic [7:0] pinctl_reg;
   logic [7:0] pinctl_next;
   logic bfa_reg;
   logic bfa_next;
   logic [15:0] cnt_reg;
   logic [15:0] cnt_next;
   logic [15:0] grc_reg;
   logic [15:0] grc_next;
   logic [15:0] gra_reg;
   logic [15:0] gra_next;
   logic access_reg;
   logic access_next;
   logic start_reg;
   logic start_next;
   logic cclr_reg;
   logic cclr_next;
   logic outen_reg;
   logic outen_next;
   logic pin_reg;
   logic pin_next;
   logic [31:0] prdata_reg;
   logic [31:0] prdata_next;

   // One driver for the whole request word
   assign req = {psel, penable, pwrite, paddr, pwdata};

   // Capture pin enters through two flip-flops
   wire pin_level;
   wire pin_rise;
   wire pin_fall;

   mtc_edge_sync u_sync (
      .clk(pclk),
      .rst_n(presetn),
      .pin(c_pin_in),
      .level(pin_level),
      .rise(pin_rise),
      .fall(pin_fall)
   );

   // Address decode
   wire sel_pinctl = (req.paddr == `MTC_OFS_PINCTL);
   wire sel_mode = (req.paddr == `MTC_OFS_MODE);
   wire sel_cnt = (req.paddr == `MTC_OFS_COUNT);
   wire sel_grc = (req.paddr == `MTC_OFS_GRC);
   wire sel_gra = (req.paddr == `MTC_OFS_GRA);
   wire sel_access = (req.paddr == `MTC_OFS_ACCESS);
   wire sel_start = (req.paddr == `MTC_OFS_START);
   wire sel_ctrl = (req.paddr == `MTC_OFS_CTRL);
   wire sel_outen = (req.paddr == `MTC_OFS_OUTEN);
   wire sel_status = (req.paddr == `MTC_OFS_STATUS);

   wire sel_prot = sel_pinctl | sel_mode | sel_cnt | sel_gra | sel_ctrl | sel_outen;
   wire sel_open = sel_grc | sel_access | sel_start | sel_status;
   wire mapped = sel_prot | sel_open;

   // Zero wait states: every access completes in its first access cycle
   wire setup_cyc = req.psel & ~req.penable;
   wire wr_cyc = req.psel & req.penable & req.pwrite;
   wire wr_prot_ok = wr_cyc & access_reg;

   wire wr_pinctl = wr_prot_ok & sel_pinctl;
   wire wr_mode = wr_prot_ok & sel_mode;
   wire wr_cnt = wr_prot_ok & sel_cnt;
   wire wr_gra = wr_prot_ok & sel_gra;
   wire wr_ctrl = wr_prot_ok & sel_ctrl;
   wire wr_outen = wr_prot_ok & sel_outen;
   wire wr_grc = wr_cyc & sel_grc;
   wire wr_access = wr_cyc & sel_access;
   wire wr_start = wr_cyc & sel_start;

   assign pready = 1'b1;
   assign pslverr = req.psel & req.penable & ~mapped;

   // Pin control decode, current and newly written
   mtc_pin_ctrl_t pc;
   mtc_pin_ctrl_t pc_new;

   assign pc = mtc_decode(pinctl_reg);
   assign pc_new = mtc_decode(req.pwdata[7:0]);

   // Counter and matches
   wire match_a = start_reg & (cnt_reg == gra_reg);
   wire match_c_raw = start_reg & (cnt_reg == grc_reg);
   wire clear_cnt = match_a & cclr_reg;

   // Buffer mode turns C into the A buffer, so C raises no events
   wire c_active = ~bfa_reg;
   wire compare_c = c_active & ~pc.capture & match_c_raw;
   wire edge_hit = (pc.cap_rise & pin_rise) | (pc.cap_fall & pin_fall);
   wire capture_c = c_active & pc.capture & edge_hit;
   wire buf_xfer = bfa_reg & match_a;

   always_comb begin
      cnt_next = cnt_reg;
      if (clear_cnt) begin
         cnt_next = `MTC_RST_COUNT;
      end else if (wr_cnt) begin
         cnt_next = req.pwdata[15:0];
      end else if (start_reg) begin
         cnt_next = cnt_reg + 16'h0001;
      end
   end

   always_comb begin
      grc_next = grc_reg;
      if (capture_c) begin
         grc_next = cnt_reg;
      end else if (wr_grc) begin
         grc_next = req.pwdata[15:0];
      end
   end

   always_comb begin
      gra_next = gra_reg;
      if (wr_gra) begin
         gra_next = req.pwdata[15:0];
      end else if (buf_xfer) begin
         gra_next = grc_reg;
      end
   end

   // Pin level: initial level on write, action on compare match
   always_comb begin
      pin_next = pin_reg;
      if (wr_pinctl) begin
         if (!pc_new.capture && pc_new.act != MTC_ACT_KEEP) begin
            pin_next = pc_new.init_high;
         end
      end else if (compare_c) begin
         unique case (pc.act)
            MTC_ACT_KEEP: pin_next = pin_reg;
            MTC_ACT_LOW: pin_next = 1'b0;
            MTC_ACT_HIGH: pin_next = 1'b1;
            MTC_ACT_TOGGLE: pin_next = ~pin_reg;
         endcase
      end
   end

   assign pinctl_next = wr_pinctl ? req.pwdata[7:0] : pinctl_reg;
   assign bfa_next = wr_mode ? req.pwdata[`MTC_BIT_BFA] : bfa_reg;
   assign cclr_next = wr_ctrl ? req.pwdata[`MTC_BIT_CCLR] : cclr_reg;
   assign outen_next = wr_outen ? req.pwdata[`MTC_BIT_OUTEN] : outen_reg;
   assign access_next = wr_access ? req.pwdata[`MTC_BIT_ACCESS] : access_reg;
   assign start_next = wr_start ? req.pwdata[`MTC_BIT_START] : start_reg;

   // Read mux; blocked reads give zero as their undefined value
   wire rd_blocked = sel_prot & ~access_reg;

   always_comb begin
      prdata_next = 32'h0000_0000;
      if (!rd_blocked) begin
         unique case (1'b1)
            sel_pinctl: prdata_next[7:0] = pinctl_reg;
            sel_mode: prdata_next[`MTC_BIT_BFA] = bfa_reg;
            sel_cnt: prdata_next[15:0] = cnt_reg;
            sel_grc: prdata_next[15:0] = grc_reg;
            sel_gra: prdata_next[15:0] = gra_reg;
            sel_access: prdata_next[`MTC_BIT_ACCESS] = access_reg;
            sel_start: prdata_next[`MTC_BIT_START] = start_reg;
            sel_ctrl: prdata_next[`MTC_BIT_CCLR] = cclr_reg;
            sel_outen: prdata_next[`MTC_BIT_OUTEN] = outen_reg;
            sel_status: prdata_next[2:0] = {start_reg, pin_level, pin_reg};
            default: prdata_next = 32'h0000_0000;
         endcase
      end
   end

   // Read data sampled in setup, stable through the access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= 32'h0000_0000;
      end else if (setup_cyc) begin
         prdata_reg <= prdata_next;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pinctl_reg <= `MTC_RST_PINCTL;
         bfa_reg <= 1'b0;
         cclr_reg <= 1'b0;
         outen_reg <= 1'b0;
         access_reg <= `MTC_RST_ACCESS;
         start_reg <= 1'b0;
      end else begin
         pinctl_reg <= pinctl_next;
         bfa_reg <= bfa_next;
         cclr_reg <= cclr_next;
         outen_reg <= outen_next;
         access_reg <= access_next;
         start_reg <= start_next;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_reg <= `MTC_RST_COUNT;
         grc_reg <= `MTC_RST_GR;
         gra_reg <= `MTC_RST_GR;
      end else begin
         cnt_reg <= cnt_next;
         grc_reg <= grc_next;
         gra_reg <= gra_next;
      end
   end

   // Reset code retains, so the pin holds low until first written
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_reg <= 1'b0;
      end else begin
         pin_reg <= pin_next;
      end
   end

   assign prdata = prdata_reg;
   assign c_pin_out = pin_reg;
   // Driver released while the pin is a capture input
   assign c_pin_oe = outen_reg & ~pc.capture;
endmodule
`default_nettype wire

// [core/mtc_timer_regs.svh]
// Register offsets, field positions, reset values for the channel 4 timer
`ifndef MTC_TIMER_REGS_SVH
`define MTC_TIMER_REGS_SVH
`define MTC_OFS_PINCTL 8'h00
`define MTC_OFS_MODE 8'h04
`define MTC_OFS_COUNT 8'h08
`define MTC_OFS_GRC 8'h0c
`define MTC_OFS_GRA 8'h10
`define MTC_OFS_ACCESS 8'h14
`define MTC_OFS_START 8'h18
`define MTC_OFS_CTRL 8'h1c
`define MTC_OFS_OUTEN 8'h20
`define MTC_OFS_STATUS 8'h24
`define MTC_BIT_BFA 0
`define MTC_BIT_ACCESS 0
`define MTC_BIT_START 0
`define MTC_BIT_CCLR 0
`define MTC_BIT_OUTEN 0
`define MTC_RST_PINCTL 8'h00
`define MTC_RST_COUNT 16'h0000
`define MTC_RST_GR 16'hffff
`define MTC_RST_ACCESS 1'b1
`endif

// [core/mtc_pkg.sv]
// Types and decode helpers for the channel 4 timer
package mtc_pkg;
   typedef enum logic [1:0] {
      MTC_ACT_KEEP = 2'h0,
      MTC_ACT_LOW = 2'h1,
      MTC_ACT_HIGH = 2'h2,
      MTC_ACT_TOGGLE = 2'h3
   } mtc_act_t;
   typedef struct packed {
      logic capture;
      logic init_high;
      mtc_act_t act;
      logic cap_rise;
      logic cap_fall;
   } mtc_pin_ctrl_t;
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } mtc_apb_req_t;

   // Splits the low pin control nibble into its actions
   function automatic mtc_pin_ctrl_t mtc_decode(input logic [7:0] v);
      mtc_pin_ctrl_t p;
      p.capture = v[3];
      p.init_high = v[2];
      p.act = mtc_act_t'(v[1:0]);
      p.cap_rise = v[1] | ~v[0];
      p.cap_fall = v[1] | v[0];
      return p;
   endfunction
endpackage

// [core/mtc_edge_sync.sv]
// Pin synchroniser with edge detection
`timescale 1ns/10ps
`default_nettype none
module mtc_edge_sync (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Pin
   input wire logic pin,
   // Detected events
   output logic level,
   output logic rise,
   output logic fall
);
   logic meta_reg;
   logic sync_reg;
   logic last_reg;

   // First stage feeds only the second stage
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         last_reg <= 1'b0;
      end else begin
         meta_reg <= pin;
         sync_reg <= meta_reg;
         last_reg <= sync_reg;
      end
   end

   assign level = sync_reg;
   assign rise = sync_reg & ~last_reg;
   assign fall = ~sync_reg & last_reg;
endmodule
`default_nettype wire

// [tb/mtc_ch4_checker.sv]
// Port-level assertions for the channel 4 timer
`include "mtc_timer_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module mtc_ch4_checker (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Pin
   input wire logic c_pin_in,
   input wire logic c_pin_out,
   input wire logic c_pin_oe
);
   logic acc_reg;
   logic run_reg;
   logic seen_reg;
   wire logic wr = psel && penable && pwrite;
   wire logic pin_wr = wr && paddr == `MTC_OFS_PINCTL && acc_reg;
   wire logic prot = paddr inside {8'h00, 8'h04, 8'h08, 8'h10, 8'h1c, 8'h20};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_reg <= 1'b1;
         run_reg <= 1'b0;
         seen_reg <= 1'b0;
      end else begin
         if (wr && paddr == `MTC_OFS_ACCESS) acc_reg <= pwdata[0];
         if (wr && paddr == `MTC_OFS_START) run_reg <= pwdata[0];
         if (pin_wr) seen_reg <= 1'b1;
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Blocked read: setup then access
   sequence s_rd_blk;
      psel && !penable && !pwrite && prot && !acc_reg ##1 psel && penable;
   endsequence
   pin_reset_a: assert property (!seen_reg |-> !c_pin_out)
      else $error("pin left low level before first control write");
   init_low_a: assert property (pin_wr && pwdata[3:2] == 2'b00 && pwdata[1:0] != 2'b00
      |=> !c_pin_out) else $error("initial low level missing");
   init_high_a: assert property (pin_wr && pwdata[3:2] == 2'b01 && pwdata[1:0] != 2'b00
      |=> c_pin_out) else $error("initial high level missing");
   keep_lvl_a: assert property (pin_wr && !pwdata[3] && pwdata[1:0] == 2'b00 && !run_reg
      |=> $stable(c_pin_out)) else $error("retain code changed the pin");
   cap_oe_a: assert property (pin_wr && pwdata[3] |=> !c_pin_oe)
      else $error("pin driven in capture mode");
   blk_read_a: assert property (s_rd_blk |-> prdata == 32'h0)
      else $error("blocked read returned data");
   blk_write_a: assert property (wr && paddr == `MTC_OFS_PINCTL && !acc_reg && !run_reg
      |=> $stable(c_pin_out)) else $error("blocked write took effect");
   bad_addr_a: assert property (psel && penable && paddr > `MTC_OFS_STATUS |-> pslverr)
      else $error("unmapped access not flagged");
   ready_a: assert property (psel && penable |-> pready)
      else $error("access phase not answered");
   good_addr_a: assert property (psel && penable && paddr <= `MTC_OFS_STATUS
      && paddr[1:0] == 2'b00 |-> !pslverr) else $error("mapped access flagged as error");
endmodule
bind mtc_ch4_timer mtc_ch4_checker u_mtc_ch4_checker (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .c_pin_in(c_pin_in),
   .c_pin_out(c_pin_out), .c_pin_oe(c_pin_oe));
`default_nettype wire

// [tb/mtc_pin_model.sv]
// Model of the circuitry that drives the capture pin
`timescale 1ns/10ps
`default_nettype none
module mtc_pin_model (
   // Pin
   output var logic pin
);
   initial pin = 1'b0;
   // Level holds between edges; the pin is an input only
   task automatic drive(input logic v);
      pin <= v;
   endtask
endmodule
`default_nettype wire

// [tb/mtc_ch4_timer_bench.sv]
// Self-checking bench for the channel 4 timer
`include "mtc_timer_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module mtc_ch4_timer_bench;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic c_pin_in, c_pin_out, c_pin_oe;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] c;
   int num_errors = 0;
   int cmp_count = 0;
   int n, k;
   mtc_ch4_timer u_mtc_ch4_timer (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .c_pin_in(c_pin_in), .c_pin_out(c_pin_out),
      .c_pin_oe(c_pin_oe));
   mtc_pin_model u_mtc_pin_model (.pin(c_pin_in));
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task rdc(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask
   task pinchk(input logic e);
      @(posedge pclk);
      chk({31'h0, c_pin_out}, {31'h0, e});
   endtask
   // Edges until the pin changes, bounded so a stuck pin cannot hang
   task edges;
      c[0] = c_pin_out;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (c_pin_out === c[0] && k < 100);
   endtask
   task cap(input logic v, input logic hit);
      wr(`MTC_OFS_GRC, 32'hffff);
      u_mtc_pin_model.drive(v);
      repeat (6) @(posedge pclk);
      rdc(`MTC_OFS_GRC, hit ? 32'h0042 : 32'hffff);
   endtask
   task results;
      if (num_errors == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      #1000000;
      num_errors++;
      results();
   end
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      pinchk(1'b0);
      rdc(`MTC_OFS_PINCTL, 32'h0);
      rdc(`MTC_OFS_GRC, 32'hffff);
      rdc(`MTC_OFS_GRA, 32'hffff);
      rdc(`MTC_OFS_ACCESS, 32'h1);
      apb(1'b0, 8'h28, 32'h0);
      chk({31'h0, err}, 32'h1);
      // Initial level of every output code, timer stopped
      wr(`MTC_OFS_OUTEN, 32'h1);
      for (n = 0; n < 8; n++) begin
         wr(`MTC_OFS_PINCTL, (32'h3726_0145 >> (4 * n)) & 32'hf);
         pinchk(1'(8'h53 >> n));
      end
      // Level after one compare match
      wr(`MTC_OFS_GRA, 32'h9);
      wr(`MTC_OFS_GRC, 32'h5);
      wr(`MTC_OFS_CTRL, 32'h1);
      for (n = 1; n < 8; n++) begin
         c = 4'(n);
         if (n == 4) continue;
         wr(`MTC_OFS_COUNT, 32'h0);
         wr(`MTC_OFS_PINCTL, {28'h0, c});
         wr(`MTC_OFS_START, 32'h1);
         repeat (8) @(posedge pclk);
         wr(`MTC_OFS_START, 32'h0);
         pinchk(c[1:0] == 2'h2 || (c[1:0] == 2'h3 && !c[2]));
      end
      // Toggle spacing gives the counter period
      wr(`MTC_OFS_PINCTL, 32'h3);
      wr(`MTC_OFS_START, 32'h1);
      edges();
      edges();
      chk(k, 32'd10);
      // Clear each edge wins over a counter write
      wr(`MTC_OFS_START, 32'h0);
      wr(`MTC_OFS_COUNT, 32'h0);
      wr(`MTC_OFS_GRA, 32'h0);
      wr(`MTC_OFS_START, 32'h1);
      wr(`MTC_OFS_COUNT, 32'h55);
      rdc(`MTC_OFS_COUNT, 32'h0);
      wr(`MTC_OFS_START, 32'h0);
      // Protection
      wr(`MTC_OFS_ACCESS, 32'h0);
      wr(`MTC_OFS_PINCTL, 32'h5);
      rdc(`MTC_OFS_PINCTL, 32'h0);
      wr(`MTC_OFS_GRC, 32'h1234);
      rdc(`MTC_OFS_GRC, 32'h1234);
      wr(`MTC_OFS_ACCESS, 32'h1);
      rdc(`MTC_OFS_PINCTL, 32'h3);
      // Capture edges per code; third bit has no effect
      wr(`MTC_OFS_COUNT, 32'h42);
      for (n = 0; n < 4; n++) begin
         c = 4'(32'hea98 >> (4 * n));
         wr(`MTC_OFS_PINCTL, {28'h0, c});
         // Enable follows the control register at the write edge; checked on the next edge
         @(posedge pclk);
         chk({31'h0, c_pin_oe}, 32'h0);
         cap(1'b1, c[1] || !c[0]);
         cap(1'b0, c[1] || c[0]);
      end
      // Buffer mode blocks capture
      wr(`MTC_OFS_MODE, 32'h1);
      cap(1'b1, 1'b0);
      // Restart after a fault: normal mode, outputs off, set up, back on, run
      wr(`MTC_OFS_MODE, 32'h0);
      wr(`MTC_OFS_OUTEN, 32'h0);
      wr(`MTC_OFS_CTRL, 32'h1);
      wr(`MTC_OFS_PINCTL, 32'h1);
      wr(`MTC_OFS_OUTEN, 32'h1);
      wr(`MTC_OFS_START, 32'h1);
      // Running, pin input still high from the last capture, output low
      rdc(`MTC_OFS_STATUS, 32'h6);
      chk({31'h0, c_pin_oe}, 32'h1);
      results();
   end
endmodule
`default_nettype wire
